// ==== dv/tb_top.sv ====
/*
  self-checking bench for the wake event block over axi4-lite.
  assumes the register map at four times the printed index.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top;
  localparam logic [11:0] A_CTL = 12'h314, A_FLG = 12'h318, A_STS = 12'h31C, A_EN = 12'h320;
  localparam logic [1:0]  OK = wake_pkg::RESP_OKAY, SE = wake_pkg::RESP_SLVERR;
  logic        aclk, aresetn, wake_request_n;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, src;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          mismatches, checks, cyc, wakes;
  logic [7:0]  exp_v;

  wake_event_status_logic dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ring_indicate_port2(src[0]), .ring_indicate_port1(src[1]),
    .keyboard_wake(src[2]), .mouse_wake(src[3]), .wake_request_n);
  wake_pm_model pm (.aclk, .aresetn, .wake_request_n, .wakes);

  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one write; bready raised once both halves are taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = OK);
    bit ad, wd;
    ad = 0;
    wd = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (s_axi_awready && !ad) begin ad = 1; s_axi_awvalid <= 1'b0; end
      if (s_axi_wready && !wd) begin wd = 1; s_axi_wvalid <= 1'b0; end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
  endtask
  // one read checked against expected byte and response
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er = OK);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, {24'h0, e})
    `CHK(s_axi_rresp, er)
  endtask
  task automatic pulse(input int i);
    src <= 4'h1 << i;
    @(posedge aclk);
    src <= 4'h0;
  endtask

  task automatic t_reset;
    rd(A_CTL, 8'h00);
    rd(A_FLG, 8'h00);
    rd(A_STS, 8'h00);
    rd(A_EN, 8'h00);
    `CHK(wake_request_n, 1'b1)
    $display("test reset done");
  endtask
  task automatic t_regs;
    wr(A_EN, 8'hFF);
    rd(A_EN, 8'h1E);
    s_axi_wstrb <= 4'hE;
    wr(A_EN, 8'h00);
    s_axi_wstrb <= 4'hF;
    rd(A_EN, 8'h1E);
    wr(A_CTL, 8'hFF);
    rd(A_CTL, 8'h01);
    wr(12'h324, 8'hFF, SE);
    rd(12'h324, 8'h00, SE);
    wr(A_EN, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_record;
    exp_v = 8'h00;
    for (int i = 0; i < 4; i++) begin
      pulse(i);
      exp_v |= 8'h02 << i;
      rd(A_STS, exp_v);
    end
    repeat (4) @(posedge aclk);
    rd(A_STS, 8'h1E);
    rd(A_FLG, 8'h00);
    `CHK(wake_request_n, 1'b1)
    wr(A_STS, 8'hE1);
    rd(A_STS, 8'h1E);
    exp_v = 8'h1E;
    for (int i = 0; i < 4; i++) begin
      wr(A_STS, 8'h02 << i);
      exp_v &= ~(8'h02 << i);
      rd(A_STS, exp_v);
    end
    $display("test record done");
  endtask
  task automatic t_wake;
    wr(A_EN, 8'h10);
    pulse(3);
    repeat (4) @(posedge aclk);
    `CHK(wake_request_n, 1'b0)
    rd(A_FLG, 8'h01);
    wr(A_FLG, 8'h00);
    rd(A_FLG, 8'h01);
    `CHK(wake_request_n, 1'b0)
    wr(A_STS, 8'h10);
    wr(A_FLG, 8'h01);
    @(posedge aclk);
    `CHK(wake_request_n, 1'b1)
    rd(A_FLG, 8'h00);
    $display("test wake done");
  endtask
  task automatic t_gate;
    wr(A_CTL, 8'h00);
    wr(A_EN, 8'h08);
    pulse(2);
    repeat (4) @(posedge aclk);
    `CHK(wake_request_n, 1'b1)
    rd(A_FLG, 8'h01);
    wr(A_CTL, 8'h01);
    @(posedge aclk);
    `CHK(wake_request_n, 1'b0)
    wr(A_STS, 8'h08);
    wr(A_FLG, 8'h01);
    @(posedge aclk);
    `CHK(wake_request_n, 1'b1)
    `CHK(wakes, 2)
    $display("test gate done");
  endtask

  // reset, then the scenarios in order
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, src} = 60'h0;
    s_axi_wstrb = 4'hF;
    cyc = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_regs();
    t_record();
    t_wake();
    t_gate();
    conclude();
  end
endmodule

// ==== dv/wake_checker.sv ====
/*
  port-level assertions for the wake event block.
  assumes one clock, aclk, and a synchronous active-low aresetn.
*/
`timescale 1ns/100ps
module wake_checker (
  input wire logic        aclk,           // clock
  input wire logic        aresetn,        // standby reset
  input wire logic        s_axi_awvalid,  // aw valid
  input wire logic        s_axi_awready,  // aw ready
  input wire logic        s_axi_wvalid,   // w valid
  input wire logic        s_axi_wready,   // w ready
  input wire logic [1:0]  s_axi_bresp,    // b resp
  input wire logic        s_axi_bvalid,   // b valid
  input wire logic        s_axi_bready,   // b ready
  input wire logic [11:0] s_axi_araddr,   // ar address
  input wire logic        s_axi_arvalid,  // ar valid
  input wire logic        s_axi_arready,  // ar ready
  input wire logic [31:0] s_axi_rdata,    // r data
  input wire logic [1:0]  s_axi_rresp,    // r resp
  input wire logic        s_axi_rvalid,   // r valid
  input wire logic        s_axi_rready,   // r ready
  input wire logic        ring_indicate_port2, // source
  input wire logic        ring_indicate_port1, // source
  input wire logic        keyboard_wake,  // source
  input wire logic        mouse_wake,     // source
  input wire logic        wake_request_n  // request line
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic       seen_q;  // some source fired since reset
  logic [9:0] ra_q;    // word index of last read taken
  wire        ar_take = s_axi_arvalid && s_axi_arready;
  wire        ar_hit  = s_axi_araddr[11:2] >= 10'h0C5 && s_axi_araddr[11:2] <= 10'h0C8;
  // remember cause and read index
  always_ff @(posedge aclk) begin
    seen_q <= aresetn && (seen_q || ring_indicate_port2 || ring_indicate_port1
                          || keyboard_wake || mouse_wake);
    ra_q   <= !aresetn ? 10'h000 : ar_take ? s_axi_araddr[11:2] : ra_q;
  end
  req_reset_a: assert property (disable iff (1'b0) !aresetn |=> wake_request_n)
    else $error("request line not released by reset");
  req_cause_a: assert property ($fell(wake_request_n) |-> $past(seen_q, 2))
    else $error("request line fell without an early source event");
  rsv_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:5] == 27'h0)
    else $error("reserved read bits not zero");
  ctl_bits_a: assert property (s_axi_rvalid && ra_q inside {10'h0C5, 10'h0C6}
    |-> s_axi_rdata[31:1] == 31'h0) else $error("control or flag upper bits set");
  src_bit0_a: assert property (s_axi_rvalid && ra_q inside {10'h0C7, 10'h0C8}
    |-> !s_axi_rdata[0]) else $error("source register bit0 set");
  unmapped_a: assert property (ar_take && !ar_hit |=> s_axi_rresp == 2'h2 && s_axi_rdata == 0)
    else $error("unmapped read not refused");
  rd_answer_a: assert property (ar_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before ready");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && !s_axi_bvalid |-> ##2 s_axi_bvalid) else $error("write answer not two edges later");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before ready");
endmodule

bind wake_event_status_logic wake_checker chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .ring_indicate_port2, .ring_indicate_port1, .keyboard_wake, .mouse_wake, .wake_request_n);

// ==== dv/wake_pm_model.sv ====
/*
  power-management receiver: counts wake requests on the active-low line.
  assumes the line is sampled on aclk and only read, never driven.
*/
`timescale 1ns/100ps
module wake_pm_model (
  input  wire logic aclk,           // clock
  input  wire logic aresetn,        // standby reset
  input  wire logic wake_request_n, // request line
  output int        wakes           // requests seen
);
  logic last_q;  // line level one edge ago
  // count each high-to-low change of the request
  always_ff @(posedge aclk) begin
    last_q <= !aresetn || wake_request_n;
    wakes  <= !aresetn ? 0 : (last_q && !wake_request_n) ? wakes + 1 : wakes;
  end
endmodule

// ==== rtl/wake_event_status_logic.sv ====
/*
  wake event status logic: axi4-lite register slave, per-source enables,
  global assertion enable, sticky status and the wake request line.
  assumes aresetn is the standby-supply power-on reset; main-supply,
  soft and hard resets never reach this block, so its state survives them.
*/
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/100ps
module wake_event_status_logic (
  input  wire logic        aclk,                // 40 MHz system clock
  input  wire logic        aresetn,             // standby power-on reset, sync
  // axi4-lite write address
  input  wire logic [11:0] s_axi_awaddr,        // write byte address
  input  wire logic        s_axi_awvalid,       // write address valid
  output logic             s_axi_awready,       // write address ready
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,         // write data
  input  wire logic [3:0]  s_axi_wstrb,         // byte lanes
  input  wire logic        s_axi_wvalid,        // write data valid
  output logic             s_axi_wready,        // write data ready
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,         // write response
  output logic             s_axi_bvalid,        // response valid
  input  wire logic        s_axi_bready,        // response ready
  // axi4-lite read address
  input  wire logic [11:0] s_axi_araddr,        // read byte address
  input  wire logic        s_axi_arvalid,       // read address valid
  output logic             s_axi_arready,       // read address ready
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,         // read data
  output logic [1:0]       s_axi_rresp,         // read response
  output logic             s_axi_rvalid,        // read data valid
  input  wire logic        s_axi_rready,        // read data ready
  // wake sources
  input  wire logic        ring_indicate_port2, // second port ring event
  input  wire logic        ring_indicate_port1, // first port ring event
  input  wire logic        keyboard_wake,       // keyboard event
  input  wire logic        mouse_wake,          // mouse event
  // toward power management
  output logic             wake_request_n       // active-low wake request
);

  typedef struct packed {
    // write address and data holding
    logic                          aw_held;
    logic [wake_pkg::ADDR_W-1:0]   aw_addr;
    logic                          w_held;
    logic [7:0]                    w_data;
    logic                          w_lane0;
    // channel handshake outputs
    logic                          awready;
    logic                          wready;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          arready;
    logic                          rvalid;
    logic [wake_pkg::DATA_W-1:0]   rdata;
    logic [1:0]                    rresp;
    // software-owned configuration
    logic [3:0]                    src_enable;
    logic                          assert_en;
  } regs_t;

  regs_t s_q;
  regs_t s_d;

  wake_if wk ();

  logic wr_fire;
  logic wr_lane;

  // true for any index this block answers
  function automatic logic is_mapped(input logic [wake_pkg::ADDR_W-1:0] addr);
    return wake_pkg::addr_hit(addr, wake_pkg::IDX_ASSERT_CTRL)
         | wake_pkg::addr_hit(addr, wake_pkg::IDX_EVENT_FLAG)
         | wake_pkg::addr_hit(addr, wake_pkg::IDX_SRC_STATUS)
         | wake_pkg::addr_hit(addr, wake_pkg::IDX_SRC_ENABLE);
  endfunction

  // places a source vector at its register bits, reserved bits zero
  function automatic logic [7:0] src_field(input logic [3:0] v);
    logic [7:0] b;
    b = 8'h00;
    b[wake_pkg::SRC_MSB:wake_pkg::SRC_LSB] = v;
    return b;
  endfunction

  // read word for an address, narrow data in the low byte
  function automatic logic [31:0] read_word(input logic [wake_pkg::ADDR_W-1:0] addr,
                                            input regs_t r,
                                            input logic [3:0] status,
                                            input logic flag);
    logic [7:0] b;
    b = 8'h00;
    if (wake_pkg::addr_hit(addr, wake_pkg::IDX_ASSERT_CTRL)) begin
      b[wake_pkg::BIT_ASSERT_EN] = r.assert_en;
    end else if (wake_pkg::addr_hit(addr, wake_pkg::IDX_EVENT_FLAG)) begin
      b[wake_pkg::BIT_FLAG] = flag;
    end else if (wake_pkg::addr_hit(addr, wake_pkg::IDX_SRC_STATUS)) begin
      b = src_field(status);
    end else if (wake_pkg::addr_hit(addr, wake_pkg::IDX_SRC_ENABLE)) begin
      b = src_field(r.src_enable);
    end
    return {24'h000000, b};
  endfunction

  // picks a source vector out of a written byte
  function automatic logic [3:0] src_pick(input logic [7:0] b);
    return b[wake_pkg::SRC_MSB:wake_pkg::SRC_LSB];
  endfunction

  // a write commits once address and data are both held and b is free
  assign wr_fire = s_q.aw_held & s_q.w_held & ~s_q.bvalid;
  assign wr_lane = wr_fire & s_q.w_lane0;

  // write-one-to-clear pulses; zero bits leave state alone
  always_comb begin
    wk.src_clear  = 4'h0;
    wk.flag_clear = 1'b0;
    if (wr_lane && wake_pkg::addr_hit(s_q.aw_addr, wake_pkg::IDX_SRC_STATUS)) begin
      wk.src_clear = src_pick(s_q.w_data);
    end
    if (wr_lane && wake_pkg::addr_hit(s_q.aw_addr, wake_pkg::IDX_EVENT_FLAG)) begin
      wk.flag_clear = s_q.w_data[wake_pkg::BIT_FLAG];
    end
  end

  // configuration toward the request generator
  assign wk.src_enable = s_q.src_enable;
  assign wk.assert_en  = s_q.assert_en;

  // next state of the bus slave and configuration
  always_comb begin
    s_d = s_q;

    // write address taken when valid meets the registered ready
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end

    // write data taken independently, in either order
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_held  = 1'b1;
      s_d.w_data  = s_axi_wdata[7:0];
      s_d.w_lane0 = s_axi_wstrb[0];
    end

    // commit: update configuration and raise the response
    if (wr_fire) begin
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = is_mapped(s_q.aw_addr) ? wake_pkg::RESP_OKAY : wake_pkg::RESP_SLVERR;
      if (wr_lane && wake_pkg::addr_hit(s_q.aw_addr, wake_pkg::IDX_SRC_ENABLE)) begin
        s_d.src_enable = src_pick(s_q.w_data);
      end
      if (wr_lane && wake_pkg::addr_hit(s_q.aw_addr, wake_pkg::IDX_ASSERT_CTRL)) begin
        s_d.assert_en = s_q.w_data[wake_pkg::BIT_ASSERT_EN];
      end
    end

    // response retires when the master takes it
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
      s_d.bresp  = wake_pkg::RESP_OKAY;
    end

    // read data retires when the master takes it
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
      s_d.rdata  = '0;
      s_d.rresp  = wake_pkg::RESP_OKAY;
    end

    // read address taken; answer the next cycle from live state
    if (s_axi_arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = read_word(s_axi_araddr, s_q, wk.src_status, wk.flag);
      s_d.rresp  = is_mapped(s_axi_araddr) ? wake_pkg::RESP_OKAY : wake_pkg::RESP_SLVERR;
    end

    // ready only while nothing of that channel is outstanding
    s_d.awready = ~s_d.aw_held;
    s_d.wready  = ~s_d.w_held;
    s_d.arready = ~s_d.rvalid;
  end

  // standby power-on is the only reset reaching these registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q            <= '0;
      s_q.bresp      <= wake_pkg::RESP_OKAY;
      s_q.rresp      <= wake_pkg::RESP_OKAY;
      s_q.src_enable <= wake_pkg::RST_SRC;
      s_q.assert_en  <= wake_pkg::RST_ASSERT_EN;
    end else begin
      s_q <= s_d;
    end
  end

  // sticky per-source status
  wake_source_latch u_latch (
    .aclk                (aclk),
    .aresetn             (aresetn),
    .ring_indicate_port2 (ring_indicate_port2),
    .ring_indicate_port1 (ring_indicate_port1),
    .keyboard_wake       (keyboard_wake),
    .mouse_wake          (mouse_wake),
    .wk                  (wk)
  );

  // global flag and request line
  wake_request_gen u_req (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wk      (wk)
  );

  // bus outputs straight from flops
  assign s_axi_awready  = s_q.awready;
  assign s_axi_wready   = s_q.wready;
  assign s_axi_bvalid   = s_q.bvalid;
  assign s_axi_bresp    = s_q.bresp;
  assign s_axi_arready  = s_q.arready;
  assign s_axi_rvalid   = s_q.rvalid;
  assign s_axi_rdata    = s_q.rdata;
  assign s_axi_rresp    = s_q.rresp;
  assign wake_request_n = wk.req_n;

endmodule

// ==== rtl/wake_if.sv ====
/*
  signals shared between the register block, the status latch and the
  request generator. no clock of its own; all users run on aclk.
*/
`timescale 1ns/100ps
interface wake_if;
  logic [3:0] src_status;  // sticky per-source status
  logic [3:0] src_enable;  // per-source enables
  logic [3:0] src_clear;   // one-cycle clear mask
  logic       assert_en;   // global assertion enable
  logic       flag;        // global wake event flag
  logic       flag_clear;  // one-cycle clear of the flag
  logic       req_n;       // registered request line

  modport latch (output src_status, input src_clear);
  modport drive (input src_status, src_enable, assert_en, flag_clear, output flag, req_n);
  modport regs  (input src_status, flag, req_n,
                 output src_enable, assert_en, src_clear, flag_clear);
endinterface

// ==== rtl/wake_pkg.sv ====
/*
  constants, field layout and decode helpers for the wake event block.
  assumes a 32-bit axi4-lite register port; each register is one word at
  four times its printed index.
*/
package wake_pkg;

  // register port geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int SRC_N  = 4;

  // printed register indices (byte address is four times the index)
  localparam logic [7:0] IDX_ASSERT_CTRL = 8'hC5;
  localparam logic [7:0] IDX_EVENT_FLAG  = 8'hC6;
  localparam logic [7:0] IDX_SRC_STATUS  = 8'hC7;
  localparam logic [7:0] IDX_SRC_ENABLE  = 8'hC8;

  // field positions
  localparam int BIT_ASSERT_EN = 0;
  localparam int BIT_FLAG      = 0;
  localparam int BIT_RING2     = 1;
  localparam int BIT_RING1     = 2;
  localparam int BIT_KEYBOARD  = 3;
  localparam int BIT_MOUSE     = 4;
  localparam int SRC_LSB       = BIT_RING2;
  localparam int SRC_MSB       = BIT_MOUSE;

  // reset values, all taken only at standby power-on
  localparam logic        RST_ASSERT_EN = 1'b0;
  localparam logic        RST_FLAG      = 1'b0;
  localparam logic [3:0]  RST_SRC       = 4'h0;
  localparam logic        RST_REQ_N     = 1'b1;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // true when a byte address selects the word of a given index
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    return addr[ADDR_W-1:2] == {2'h0, idx};
  endfunction

endpackage

// ==== rtl/wake_request_gen.sv ====
/*
  global wake event flag and the active-low wake request line.
  assumes status and enables come from registers on the same clock.
*/
`timescale 1ns/100ps
module wake_request_gen (
  input  wire logic  aclk,    // system clock
  input  wire logic  aresetn, // standby power-on reset, sync
  wake_if.drive      wk       // status in, flag and request out
);

  typedef struct packed {
    logic flag;
    logic req_n;
  } drive_t;

  drive_t s_q;
  drive_t s_d;
  logic   would_assert;

  // any enabled source with its status set would assert the line
  assign would_assert = |(wk.src_status & wk.src_enable);

  // flag ignores the global enable; set wins over a clear
  always_comb begin
    s_d       = s_q;
    s_d.flag  = (s_q.flag & ~wk.flag_clear) | would_assert;
    s_d.req_n = ~(s_q.flag & wk.assert_en);
  end

  // kept through every reset but standby power-on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q.flag  <= wake_pkg::RST_FLAG;
      s_q.req_n <= wake_pkg::RST_REQ_N;
    end else begin
      s_q <= s_d;
    end
  end

  assign wk.flag  = s_q.flag;
  assign wk.req_n = s_q.req_n;

endmodule

// ==== rtl/wake_source_latch.sv ====
/*
  sticky per-source wake status bits with write-one-to-clear.
  assumes the wake source inputs are synchronous to aclk and high while
  the source asserts its wake event.
*/
`timescale 1ns/100ps
module wake_source_latch (
  input  wire logic  aclk,        // system clock
  input  wire logic  aresetn,     // standby power-on reset, sync
  input  wire logic  ring_indicate_port2, // second port ring event
  input  wire logic  ring_indicate_port1, // first port ring event
  input  wire logic  keyboard_wake,       // keyboard event
  input  wire logic  mouse_wake,          // mouse event
  wake_if.latch      wk                   // status toward register block
);

  typedef struct packed {
    logic [3:0] status;
  } latch_t;

  latch_t s_q;
  latch_t s_d;
  logic [3:0] src_in;

  // sources in register bit order, highest first
  assign src_in = {mouse_wake, keyboard_wake, ring_indicate_port1, ring_indicate_port2};

  // set regardless of enables; set wins over a clear in the same cycle
  always_comb begin
    s_d        = s_q;
    s_d.status = (s_q.status & ~wk.src_clear) | src_in;
  end

  // only standby power-on resets the bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q.status <= wake_pkg::RST_SRC;
    end else begin
      s_q <= s_d;
    end
  end

  assign wk.src_status = s_q.status;

endmodule
